/* hdl/pcc_pkg.sv */
/*
 * Package for the timer clock configuration block: register map, field
 * layout of the configuration byte, reset values and decode helpers.
 * Assumes a single core clock and a byte-wide register port.
 */
package pcc_pkg;

	// register port and counter widths
	localparam int          PCC_ADDR_W   = 8;
	localparam int          PCC_DATA_W   = 8;
	localparam int          PCC_COUNT_W  = 12;

	// register offsets
	localparam logic [7:0]  PCC_CFG_ADDR  = 8'ha4;
	localparam logic [7:0]  PCC_STAT_ADDR = 8'haf;

	// field positions in the configuration byte
	localparam int          PCC_PLL_EN_BIT  = 7;
	localparam int          PCC_RATE_LSB    = 5;
	localparam int          PCC_SOURCE_BIT  = 4;
	localparam int          PCC_BOOST_BIT   = 3;
	localparam int          PCC_DIV_LSB     = 0;

	// reset values
	localparam logic [7:0]  PCC_CFG_RESET   = 8'h00;
	localparam logic [11:0] PCC_COUNT_RESET = 12'h000;

	// the PLL base tick runs at eight times the slowest rate
	localparam logic [2:0]  PCC_BASE_WRAP   = 3'h7;

	// core clock period, for reference only
	localparam int          PCC_CLK_NS      = 100;

	// configuration byte, laid out as software sees it
	typedef struct packed {
		logic       pll_enable;
		logic [1:0] pll_rate_select;
		logic       timer_clock_source;
		logic       instr_clock_boost;
		logic [2:0] timer_divider;
	} pcc_cfg_t;

	// settings that only change at run start and at counter overflow while running
	typedef struct packed {
		logic [1:0] pll_rate_select;
		logic [2:0] timer_divider;
	} pcc_applied_t;

	// rate code 0..3 gives 8..64 MHz: base tick divided by 8,4,2,1
	function automatic logic [2:0] pcc_rate_mask(input logic [1:0] code);
		pcc_rate_mask = PCC_BASE_WRAP >> code;
	endfunction

	// pull the deferred fields out of a configuration byte
	function automatic pcc_applied_t pcc_deferred(input pcc_cfg_t cfg);
		pcc_deferred.pll_rate_select = cfg.pll_rate_select;
		pcc_deferred.timer_divider   = cfg.timer_divider;
	endfunction

endpackage

/* hdl/pcc_prescaler.sv */
/*
 * Timer prescaler: passes one of every (divide + 1) input ticks.
 * Assumes tick_in is a one-cycle pulse on the core clock.
 */
`timescale 1ns/1ns
module pcc_prescaler
	import pcc_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// control
	input  wire logic       tick_in,
	input  wire logic       restart,
	input  wire logic [2:0] divide,
	// tick out
	output logic            tick_out
);
	logic [2:0] cnt;  // input ticks seen in this period
	logic       wrap; // last tick of the period

	assign wrap     = (cnt == divide);
	// not gated by restart: the overflow that raises restart is itself
	// made from this tick, so gating it here would close a loop
	assign tick_out = tick_in && wrap;

	// period counter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 3'h0;
		end else if (restart) begin
			cnt <= 3'h0;
		end else if (tick_in) begin
			cnt <= wrap ? 3'h0 : cnt + 3'h1;
		end
	end

endmodule // pcc_prescaler

/* hdl/pcc_rate_div.sv */
/*
 * PLL rate clock enable generator. Divides the PLL base tick down to
 * the selected rate and to the fixed divide-by-8 instruction rate.
 * Assumes base_tick is a one-cycle pulse on the core clock.
 */
`timescale 1ns/1ns
module pcc_rate_div
	import pcc_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// control
	input  wire logic       base_tick,
	input  wire logic       restart,
	input  wire logic [1:0] rate_code,
	// ticks out
	output logic            rate_tick,
	output logic            slow_tick
);
	logic [2:0] phase;  // position within eight base ticks
	logic [2:0] mask;   // phase bits that must all be set

	assign mask      = pcc_rate_mask(rate_code);
	assign rate_tick = base_tick && ((phase & mask) == mask);
	assign slow_tick = base_tick && (phase == PCC_BASE_WRAP);

	// phase counter, cleared while restart is high, which pcc_top drives only while the PLL is off
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= 3'h0;
		end else if (restart) begin
			phase <= 3'h0;
		end else if (base_tick) begin
			phase <= phase + 3'h1;
		end
	end

endmodule // pcc_rate_div

/* hdl/pcc_top.sv */
/*
 * Timer clock configuration block: the configuration register, the
 * instruction and timer base clock selection, the prescaler and the
 * 12-bit timer counter with its overflow.
 * Assumes PLL_TICK, OSC_TICK, TIMER_RUN and TIMER_TOP come from logic
 * on CORE_CLK; the clocks are modelled as one-cycle enable ticks.
 */
`timescale 1ns/1ns
module pcc_top
	import pcc_pkg::*;
(
	// clock and reset
	input  wire logic                         CORE_CLK,
	input  wire logic                         NRST,
	// register port
	input  wire logic [pcc_pkg::PCC_ADDR_W-1:0] ADDR,
	input  wire logic [pcc_pkg::PCC_DATA_W-1:0] WR_DATA,
	input  wire logic                         WR_EN,
	input  wire logic                         RD_EN,
	output logic [pcc_pkg::PCC_DATA_W-1:0]    RD_DATA,
	// clock sources as enable ticks
	input  wire logic                         PLL_TICK,
	input  wire logic                         OSC_TICK,
	// timer control
	input  wire logic                         TIMER_RUN,
	input  wire logic [pcc_pkg::PCC_COUNT_W-1:0] TIMER_TOP,
	// clock outputs
	output logic                              PLL_ENABLE,
	output logic                              INSTR_CLOCK_TICK,
	output logic                              TIMER_BASE_TICK,
	// timer outputs
	output logic [pcc_pkg::PCC_COUNT_W-1:0]   TIMER_COUNT,
	output logic                              TIMER_OVERFLOW
);
	import pcc_pkg::*;

	// clocking scheme
	// every clock of the structure is a one-cycle enable on CORE_CLK,
	// so the block stays in one domain and no clock is gated or muxed;
	// the price is that no rate can exceed one tick per core cycle
	//
	// the PLL base tick feeds the rate divider, which yields both the
	// selected rate tick and the fixed divide-by-8 tick that can boost
	// the instruction clock; the oscillator tick is halved for the
	// slow instruction clock
	//
	// the timer base tick is one of those two, and the prescaler
	// passes one of every (code + 1) base ticks on to the counter
	//
	// run mode handling
	// software reads back the byte as filtered at the write; the rate and prescale
	// codes in force sit in a separate shadow, loaded while stopped, at run start
	// and at overflow, so a cycle in progress changes speed only if the boost bit is written while the timer runs on the instruction clock
	//
	// the enable and source bits are filtered at the write itself, so
	// there is no second copy of them to keep in step
	//
	// limitation: the PLL lock time is not modelled; software has to
	// wait it out before it selects a PLL-derived clock
	//
	// limitation: lowering TIMER_TOP below the running count lets the
	// count run on to its natural wrap with no overflow pulse; the top
	// value is meant to change only at overflow

	// reset synchroniser stages
	logic         rst_meta;
	logic         rst_n;

	// software visible configuration
	pcc_cfg_t     cfg;
	pcc_cfg_t     next_cfg;

	// settings in force for the current cycle
	pcc_applied_t applied;
	pcc_applied_t next_applied;

	// decoded accesses
	logic         cfg_wr;
	logic         cfg_rd;
	logic         stat_rd;
	pcc_cfg_t     wr_cfg;

	// clock enables
	logic         rate_tick;
	logic         slow_tick;
	logic         osc_half;
	logic         instr_tick;
	logic         base_tick;
	logic         count_tick;

	// timer state
	logic [PCC_COUNT_W-1:0] count;
	logic [PCC_COUNT_W-1:0] next_count;
	logic         at_top;
	logic         overflow;
	logic         run_q;
	logic         run_start;
	logic         restart;

	// reset release through two flops
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// address decode
	assign cfg_wr  = WR_EN && (ADDR == PCC_CFG_ADDR);
	assign cfg_rd  = RD_EN && (ADDR == PCC_CFG_ADDR);
	assign stat_rd = RD_EN && (ADDR == PCC_STAT_ADDR);
	assign wr_cfg  = pcc_cfg_t'(WR_DATA);

	// write filter for the configuration byte
	always_comb begin
		next_cfg = cfg;
		if (cfg_wr) begin
			if (!TIMER_RUN) begin
				next_cfg.pll_enable = wr_cfg.pll_enable;
			end
			next_cfg.pll_rate_select = wr_cfg.pll_rate_select;
			next_cfg.timer_divider = wr_cfg.timer_divider;
			if (!TIMER_RUN) begin
				if (!wr_cfg.timer_clock_source) begin
					// clearing is always allowed when stopped
					next_cfg.timer_clock_source = 1'b0;
				end else if (next_cfg.pll_enable) begin
					next_cfg.timer_clock_source = 1'b1;
				end
			end
			if (next_cfg.pll_enable) begin
				next_cfg.instr_clock_boost = wr_cfg.instr_clock_boost;
			end else begin
				next_cfg.instr_clock_boost = 1'b0;
			end
		end
	end

	// configuration register
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			cfg <= pcc_cfg_t'(PCC_CFG_RESET);
		end else begin
			cfg <= next_cfg;
		end
	end

	// run edge, used to latch settings at start
	assign run_start = TIMER_RUN && !run_q;

	// applied shadow update
	always_comb begin
		next_applied = applied;
		if (!TIMER_RUN) begin
			// stopped: settings follow software directly
			next_applied = pcc_deferred(next_cfg);
		end else if (overflow || run_start) begin
			// rate and prescale taken at overflow or at run start
			// a write in the overflow cycle is included
			next_applied = pcc_deferred(next_cfg);
		end
	end

	// applied shadow register
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			applied <= pcc_deferred(pcc_cfg_t'(PCC_CFG_RESET));
		end else begin
			applied <= next_applied;
		end
	end

	// run level of the previous cycle
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			run_q <= 1'b0;
		end else begin
			run_q <= TIMER_RUN;
		end
	end

	// the prescaler restarts at overflow or while stopped
	assign restart = overflow || !TIMER_RUN;

	// pll rate clock from the base tick
	pcc_rate_div u_rate (
		.clk       (CORE_CLK),
		.rst_n     (rst_n),
		.base_tick (PLL_TICK && cfg.pll_enable),
		.restart   (!cfg.pll_enable),
		.rate_code (applied.pll_rate_select),
		.rate_tick (rate_tick),
		.slow_tick (slow_tick)
	);

	// oscillator halving for the slow instruction clock
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			osc_half <= 1'b0;
		end else if (OSC_TICK) begin
			osc_half <= !osc_half;
		end
	end

	assign instr_tick = cfg.instr_clock_boost ? slow_tick
	                                          : (OSC_TICK && osc_half);

	assign base_tick = cfg.timer_clock_source ? rate_tick : instr_tick;

	// prescaler feeding the counter
	pcc_prescaler u_pre (
		.clk      (CORE_CLK),
		.rst_n    (rst_n),
		.tick_in  (base_tick && TIMER_RUN),
		.restart  (restart),
		.divide   (applied.timer_divider),
		.tick_out (count_tick)
	);

	// the overflow uses the counted tick itself, so a top value of N
	// gives N + 1 counts per cycle; TIMER_OVERFLOW is the registered
	// copy and lines up with TIMER_COUNT showing zero
	// overflow when the top count completes
	assign at_top   = (count == TIMER_TOP);
	assign overflow = TIMER_RUN && count_tick && at_top;

	// next counter value
	always_comb begin
		next_count = count;
		if (!TIMER_RUN) begin
			// stopped counter sits at zero
			next_count = PCC_COUNT_RESET;
		end else if (overflow) begin
			next_count = PCC_COUNT_RESET;
		end else if (count_tick) begin
			next_count = count + 12'h001;
		end
	end

	// timer counter
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			count <= PCC_COUNT_RESET;
		end else begin
			count <= next_count;
		end
	end

	// registered outputs for the timer
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			TIMER_COUNT    <= PCC_COUNT_RESET;
			TIMER_OVERFLOW <= 1'b0;
		end else begin
			TIMER_COUNT    <= next_count;
			TIMER_OVERFLOW <= overflow;
		end
	end

	// registered clock outputs: the ticks one cycle behind the enables, PLL_ENABLE in step with cfg
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			PLL_ENABLE       <= 1'b0;
			INSTR_CLOCK_TICK <= 1'b0;
			TIMER_BASE_TICK  <= 1'b0;
		end else begin
			PLL_ENABLE       <= next_cfg.pll_enable;
			INSTR_CLOCK_TICK <= instr_tick;
			TIMER_BASE_TICK  <= base_tick;
		end
	end

	// read side: the configuration byte comes back as stored, while
	// the status byte shows the shadow in force, so software can tell
	// whether a deferred change has reached the counter yet
	// read data, valid only in the cycle after the strobe
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			RD_DATA <= 8'h00;
		end else if (cfg_rd) begin
			RD_DATA <= cfg;
		end else if (stat_rd) begin
			// status: run, pll, applied rate, applied prescale
			RD_DATA <= {TIMER_RUN, cfg.pll_enable,
			            applied.pll_rate_select, 1'b0,
			            applied.timer_divider};
		end else begin
			// unmapped or idle reads give zero
			RD_DATA <= 8'h00;
		end
	end

endmodule // pcc_top

/* tb/pcc_top_chk.sv */
/* Port checker for pcc_top: register and timer relations.
   Assumes a bind onto pcc_top and the single core clock. */
`timescale 1ns/1ns
module pcc_top_chk
	import pcc_pkg::*;
(
	// clock and reset
	input wire logic        CORE_CLK,
	input wire logic        NRST,
	// register port
	input wire logic [7:0]  ADDR,
	input wire logic [7:0]  WR_DATA,
	input wire logic        WR_EN,
	input wire logic        RD_EN,
	input wire logic [7:0]  RD_DATA,
	// ticks and timer
	input wire logic        PLL_TICK,
	input wire logic        OSC_TICK,
	input wire logic        TIMER_RUN,
	input wire logic [11:0] TIMER_TOP,
	input wire logic        PLL_ENABLE,
	input wire logic        INSTR_CLOCK_TICK,
	input wire logic        TIMER_BASE_TICK,
	input wire logic [11:0] TIMER_COUNT,
	input wire logic        TIMER_OVERFLOW
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);
	// config write decode, stopped timer only
	wire cfg_wr = WR_EN && ADDR == PCC_CFG_ADDR && !TIMER_RUN;

	AST_PLL_SET: assert property (cfg_wr && WR_DATA[7] |=> PLL_ENABLE)
		else $error("pll enable not set by write");
	AST_PLL_CLR: assert property (cfg_wr && !WR_DATA[7] |=> !PLL_ENABLE)
		else $error("pll enable not cleared by write");
	AST_PLL_FROZEN: assert property (TIMER_RUN |=> $stable(PLL_ENABLE))
		else $error("pll enable moved while running");
	AST_RD_IDLE: assert property (!$past(RD_EN) |-> RD_DATA == 8'h00)
		else $error("read data outside its slot");
	AST_CNT_HELD: assert property (!TIMER_RUN |=> TIMER_COUNT == 12'h000)
		else $error("count not held at zero when stopped");
	AST_CNT_STEP: assert property ($changed(TIMER_COUNT) |->
		TIMER_COUNT == $past(TIMER_COUNT) + 12'h001 || TIMER_COUNT == 12'h000)
		else $error("count jumped");
	AST_OVF_ZERO: assert property (TIMER_OVERFLOW |->
		TIMER_COUNT == 12'h000 && $past(TIMER_COUNT) == $past(TIMER_TOP))
		else $error("overflow without wrap at top");
	AST_OVF_CAUSE: assert property ($past(TIMER_COUNT) != 12'h000 && TIMER_COUNT == 12'h000
		&& $past(TIMER_RUN) |-> TIMER_OVERFLOW)
		else $error("wrap without overflow pulse");
	AST_SLOW_INSTR: assert property ((!PLL_ENABLE [*3]) ##0 INSTR_CLOCK_TICK |=> !INSTR_CLOCK_TICK)
		else $error("fast instruction tick with pll off");
	AST_BOOST_OFF: assert property ($past(RD_EN && ADDR == PCC_CFG_ADDR) && !RD_DATA[7] |-> !RD_DATA[3])
		else $error("boost bit set with pll off");
	AST_RD_PLL: assert property ($past(RD_EN && ADDR == PCC_CFG_ADDR) |-> RD_DATA[7] == $past(PLL_ENABLE))
		else $error("read enable bit differs from pll state");

	// main scenarios reached
	COV_OVF: cover property (TIMER_OVERFLOW);
	COV_RUN_WR: cover property (WR_EN && TIMER_RUN && ADDR == PCC_CFG_ADDR);
	COV_FAST: cover property (PLL_ENABLE && INSTR_CLOCK_TICK);
endmodule // pcc_top_chk

bind pcc_top pcc_top_chk u_chk (.CORE_CLK, .NRST, .ADDR, .WR_DATA, .WR_EN, .RD_EN, .RD_DATA,
	.PLL_TICK, .OSC_TICK, .TIMER_RUN, .TIMER_TOP, .PLL_ENABLE, .INSTR_CLOCK_TICK,
	.TIMER_BASE_TICK, .TIMER_COUNT, .TIMER_OVERFLOW);

/* tb/testbench.sv */
/* Self-checking bench for pcc_top: register filtering, tick spacing
   and deferred settings. Assumes PLL and oscillator ticks every cycle. */
`timescale 1ns/1ns
module testbench;
	import pcc_pkg::*;
	// driven inputs
	logic        CORE_CLK = 1'h0;
	logic        NRST = 1'h0;
	logic [7:0]  ADDR = 8'h00;
	logic [7:0]  WR_DATA = 8'h00;
	logic        WR_EN = 1'h0;
	logic        RD_EN = 1'h0;
	logic        PLL_TICK = 1'h0;
	logic        OSC_TICK = 1'h0;
	logic        TIMER_RUN = 1'h0;
	logic [11:0] TIMER_TOP = 12'hfff;
	// observed outputs
	logic [7:0]  RD_DATA;
	logic        PLL_ENABLE;
	logic        INSTR_CLOCK_TICK;
	logic        TIMER_BASE_TICK;
	logic        TIMER_OVERFLOW;
	logic [11:0] TIMER_COUNT;
	// bookkeeping
	int          failures = 0;
	int          n_checks = 0;
	int          p;
	int          ni;
	int          nb;
	logic [7:0]  cfg;
	logic [7:0]  d;
	logic [7:0]  v;
	logic [7:0]  wlist [6] = '{8'h18, 8'h7f, 8'h80, 8'h98, 8'h88, 8'h00};

	always #50 CORE_CLK = ~CORE_CLK;

	pcc_top dut (.CORE_CLK, .NRST, .ADDR, .WR_DATA, .WR_EN, .RD_EN, .RD_DATA, .PLL_TICK,
		.OSC_TICK, .TIMER_RUN, .TIMER_TOP, .PLL_ENABLE, .INSTR_CLOCK_TICK, .TIMER_BASE_TICK,
		.TIMER_COUNT, .TIMER_OVERFLOW);

	// verdict and end of run
	task test_done;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// a wait ran out
	task hang;
		failures++;
		test_done;
	endtask

	task wr(input logic [7:0] a, input logic [7:0] dat);
		@(posedge CORE_CLK);
		ADDR <= a;
		WR_DATA <= dat;
		WR_EN <= 1'h1;
		@(posedge CORE_CLK);
		WR_EN <= 1'h0;
	endtask

	// data stands only in the cycle after the strobe
	task rd(input logic [7:0] a, output logic [7:0] dat);
		@(posedge CORE_CLK);
		ADDR <= a;
		RD_EN <= 1'h1;
		@(posedge CORE_CLK);
		RD_EN <= 1'h0;
		#1 dat = RD_DATA;
	endtask

	// stored byte after a write; run freezes enable and source
	// filtering model
	function automatic logic [7:0] exp_cfg(input logic [7:0] old, input logic [7:0] w, input logic run);
		logic pll;
		pll = run ? old[7] : w[7];
		// a set with the PLL off is refused and leaves the old value
		return {pll, w[6:5], run ? old[4] : (w[4] & (pll | old[4])), w[3] & pll, w[2:0]};
	endfunction

	// cycles between two counter steps, first one aligns
	task gap(output int n);
		logic [11:0] c;
		repeat (2) begin
			c = TIMER_COUNT;
			n = 0;
			while (TIMER_COUNT === c) begin
				@(negedge CORE_CLK);
				n++;
				if (n > 300)
					hang;
			end
		end
	endtask

	// pulses of the two tick outputs over 64 cycles
	task ticks(output int i_n, output int b_n);
		i_n = 0;
		b_n = 0;
		repeat (64) begin
			@(negedge CORE_CLK);
			i_n += (INSTR_CLOCK_TICK === 1'h1);
			b_n += (TIMER_BASE_TICK === 1'h1);
		end
	endtask

	// set up while stopped, then run and measure
	task spacing(input logic [7:0] s, output int n);
		wr(PCC_CFG_ADDR, s);
		@(posedge CORE_CLK);
		TIMER_RUN <= 1'h1;
		gap(n);
		@(posedge CORE_CLK);
		TIMER_RUN <= 1'h0;
	endtask

	initial begin
		void'($urandom(32'hd79c996b));
		repeat (20) @(posedge CORE_CLK);
		NRST <= 1'h1;
		PLL_TICK <= 1'h1;
		OSC_TICK <= 1'h1;
		repeat (3) @(posedge CORE_CLK);
		rd(PCC_CFG_ADDR, d);
		chk(d, PCC_CFG_RESET);
		rd(PCC_STAT_ADDR, d);
		chk(d, 8'h00);
		// stopped writes, last one random
		cfg = PCC_CFG_RESET;
		foreach (wlist[i]) begin
			v = (i == 5) ? 8'($urandom) : wlist[i];
			wr(PCC_CFG_ADDR, v);
			cfg = exp_cfg(cfg, v, 1'h0);
			rd(PCC_CFG_ADDR, d);
			chk(d, cfg);
			chk(PLL_ENABLE, cfg[7]);
		end
		// unmapped place reads zero and leaves config alone
		wr(8'h10, 8'hff);
		rd(8'h10, d);
		chk(d, 8'h00);
		rd(PCC_CFG_ADDR, d);
		chk(d, cfg);
		wr(PCC_CFG_ADDR, 8'h80);
		repeat (16) @(posedge CORE_CLK);
		for (int c = 0; c < 4; c++) begin
			spacing({1'h1, 2'(c), 5'h10}, p);
			chk(p, 8 >> c);
			ticks(ni, nb);
			chk(nb, 8 << c);
			chk(ni, 32);
		end
		for (int k = 0; k < 8; k++) begin
			spacing({5'h10, 3'(k)}, p);
			chk(p, 2 * (k + 1));
			ticks(ni, nb);
			chk(nb, 32);
		end
		spacing(8'h88, p);
		chk(p, 8);
		ticks(ni, nb);
		chk(ni, 8);
		chk(nb, 8);
		// running: enable and source frozen, rate and prescale deferred
		TIMER_TOP <= 12'h003;
		wr(PCC_CFG_ADDR, 8'h97);
		cfg = 8'h97;
		@(posedge CORE_CLK);
		TIMER_RUN <= 1'h1;
		// source bit written unchanged while running
		v = (8'($urandom) & 8'h67) | 8'h18;
		wr(PCC_CFG_ADDR, v);
		cfg = exp_cfg(cfg, v, 1'h1);
		rd(PCC_CFG_ADDR, d);
		chk(d, cfg);
		rd(PCC_STAT_ADDR, d);
		chk(d, 8'hc7);
		p = 0;
		while (TIMER_OVERFLOW !== 1'h1) begin
			@(negedge CORE_CLK);
			p++;
			if (p > 2000)
				hang;
		end
		chk(TIMER_COUNT, 12'h000);
		rd(PCC_STAT_ADDR, d);
		chk(d, {2'h3, cfg[6:5], 1'h0, cfg[2:0]});
		@(posedge CORE_CLK);
		TIMER_RUN <= 1'h0;
		repeat (2) @(posedge CORE_CLK);
		#1 chk(TIMER_COUNT, 12'h000);
		// second reset with the timer stopped clears the register again
		@(posedge CORE_CLK);
		NRST <= 1'h0;
		repeat (2) @(posedge CORE_CLK);
		NRST <= 1'h1;
		repeat (3) @(posedge CORE_CLK);
		rd(PCC_CFG_ADDR, d);
		chk(d, PCC_CFG_RESET);
		chk(PLL_ENABLE, 1'h0);
		test_done;
	end
endmodule // testbench
